// *** rtl/uart_sir_regs.svh ***
// register offsets, field positions, reset values and counts of the uart status block
`ifndef UART_SIR_REGS_SVH
`define UART_SIR_REGS_SVH
// byte addresses, one aligned word each
`define ADDR_TX_RX 32'hFFFF0700
`define ADDR_IRQ_EN 32'hFFFF0704
`define ADDR_IRQ_IDENT 32'hFFFF0708
`define ADDR_LINE_CTRL 32'hFFFF070C
`define ADDR_LINE_STATUS 32'hFFFF0714
`define ADDR_SECOND_STATUS 32'hFFFF0718
`define ADDR_FRAC_DIV 32'hFFFF072C
// line status fields
`define LSR_IDLE_BIT 6
`define LSR_HOLD_EMPTY_BIT 5
`define LSR_BREAK_BIT 4
`define LSR_FRAME_BIT 3
`define LSR_PARITY_BIT 2
`define LSR_OVERRUN_BIT 1
`define LSR_READY_BIT 0
// interrupt enable fields
`define IEN_MODEM_BIT 3
`define IEN_LINE_BIT 2
`define IEN_TX_BIT 1
`define IEN_RX_BIT 0
`define IEN_WMASK 8'h0F
// line control: divisor latch select
`define LCR_LATCH_SEL_BIT 7
// fractional divider fields
`define FRAC_EN_BIT 15
`define FRAC_M_HI 12
`define FRAC_M_LO 11
`define FRAC_N_HI 10
`define FRAC_WMASK 16'h9FFF
`define FRAC_M_ZERO_MEANS 3'h4
// identification codes, bit 0 is the no-pending flag
`define IID_NONE 8'h01
`define IID_LINE 8'h06
`define IID_RXFULL 8'h04
`define IID_TXEMPTY 8'h02
`define IID_MODEM 8'h00
// reset values
`define IEN_RST 8'h00
`define IID_RST 8'h01
`define FRAC_RST 16'h0000
// longest frame in bit times: start, 8 data, parity, 2 stop
`define MAX_FRAME_BITS 4'hC
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** rtl/uart_sir_pkg.sv ***
// types shared by the uart status, interrupt and fractional divider block
package uart_sir_pkg;
  // one received character from the receive shifter
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic parity_err;
    logic frame_err;
  } rx_event_t;
  // fractional generator settings as the baud logic uses them
  typedef struct packed {
    logic en;
    logic [2:0] m;
    logic [10:0] n;
  } frac_cfg_t;
  // whole state of the block
  typedef struct packed {
    logic [31:0] awaddr_q;
    logic aw_held_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [7:0] line_ctrl_q;
    logic [7:0] irq_en_q;
    logic [15:0] div_q;
    logic [15:0] frac_q;
    frac_cfg_t frac_cfg_q;
    logic [7:0] hold_data_q;
    logic hold_full_q;
    logic tx_load_q;
    logic [7:0] tx_data_q;
    logic [7:0] rx_data_q;
    logic ready_q;
    logic overrun_q;
    logic parity_q;
    logic frame_q;
    logic break_q;
    logic modem_q;
    logic tx_pend_q;
    logic [7:0] iid_q;
    logic irq_q;
    logic [2:0] sync_q;
    logic line_q;
    logic [3:0] low_bits_q;
  } state_t;
endpackage

// *** rtl/uart_status_irq_fracdiv.sv ***
// uart line status, interrupt enable and identification, divisor and fractional divider over axi4-lite
`timescale 1ns/10ps
`include "uart_sir_regs.svh"
module uart_status_irq_fracdiv (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite slave
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // receive shifter events, same clock
  input wire uart_sir_pkg::rx_event_t i_rx_event,
  // transmit shifter busy, same clock
  input wire logic i_tx_busy,
  // modem status change pulse, same clock
  input wire logic i_modem_event,
  // one pulse per bit time from the baud generator
  input wire logic i_bit_tick,
  // serial receive pin, asynchronous
  input wire logic i_serial_rx_line,
  // to the shifters and baud logic, and the interrupt request
  output logic o_tx_load,
  output logic [7:0] o_tx_data,
  output logic [7:0] o_line_ctrl,
  output logic [15:0] o_divisor,
  output uart_sir_pkg::frac_cfg_t o_frac_cfg,
  output logic o_irq
);

  uart_sir_pkg::state_t s; // registered state
  uart_sir_pkg::state_t n; // next state
  // next state: bus slave, flags, transmit hand-off, break detect, priority
  always_comb
  begin
    logic latch_sel;
    logic do_wr;
    logic do_rd;
    logic [31:0] rd_val;
    logic [1:0] rd_resp;
    logic [1:0] wr_resp;
    logic [15:0] wmask;
    logic [7:0] lsr;
    logic rx_set;
    logic ls_on;
    logic rx_on;
    logic tx_on;
    logic ms_on;
    latch_sel = s.line_ctrl_q[`LCR_LATCH_SEL_BIT];
    do_wr = s.aw_held_q && s.w_held_q; // both write halves held
    do_rd = i_arvalid && s.arready_q;
    rd_val = 32'h00000000;
    rd_resp = `RESP_OKAY;
    wr_resp = `RESP_OKAY;
    wmask = {{8{s.wstrb_q[1]}}, {8{s.wstrb_q[0]}}}; // lanes 0 and 1 cover every register here
    lsr = 8'h00;
    rx_set = i_rx_event.valid; // receive shifter delivers a character
    ls_on = 1'b0;
    rx_on = 1'b0;
    tx_on = 1'b0;
    ms_on = 1'b0;
    n = s;
    // write address and data are taken in either order
    if (i_awvalid && s.awready_q)
    begin
      n.awaddr_q = i_awaddr;
      n.aw_held_q = 1'b1;
    end
    if (i_wvalid && s.wready_q)
    begin
      n.wdata_q = i_wdata;
      n.wstrb_q = i_wstrb;
      n.w_held_q = 1'b1;
    end

    // a received character sets the flags; a read clear later in this cycle loses
    if (rx_set)
    begin
      n.overrun_q = s.overrun_q | s.ready_q;
      n.rx_data_q = i_rx_event.data;
      n.ready_q = 1'b1;
      n.parity_q = s.parity_q | i_rx_event.parity_err;
      n.frame_q = s.frame_q | i_rx_event.frame_err;
    end
    if (i_modem_event)
    begin
      n.modem_q = 1'b1;
    end

    // line status as software sees it
    lsr[`LSR_IDLE_BIT] = ~s.hold_full_q & ~s.tx_load_q & ~i_tx_busy;
    lsr[`LSR_HOLD_EMPTY_BIT] = ~s.hold_full_q;
    lsr[`LSR_BREAK_BIT] = s.break_q;
    lsr[`LSR_FRAME_BIT] = s.frame_q;
    lsr[`LSR_PARITY_BIT] = s.parity_q;
    lsr[`LSR_OVERRUN_BIT] = s.overrun_q;
    lsr[`LSR_READY_BIT] = s.ready_q;

    // read decode and read side effects; a flag set this cycle survives the clear
    if (do_rd)
    begin
      case (i_araddr)
        `ADDR_TX_RX:
        begin
          if (latch_sel)
          begin
            rd_val = {24'h000000, s.div_q[7:0]};
          end
          else
          begin
            rd_val = {24'h000000, s.rx_data_q};
            if (!rx_set)
            begin
              n.ready_q = 1'b0;
            end
          end
        end
        `ADDR_IRQ_EN:
        begin
          rd_val = latch_sel ? {24'h000000, s.div_q[15:8]} : {24'h000000, s.irq_en_q};
        end
        `ADDR_IRQ_IDENT:
        begin
          rd_val = {24'h000000, s.iid_q};
          // reading the code for tx empty retires it
          if (s.iid_q == `IID_TXEMPTY)
          begin
            n.tx_pend_q = 1'b0;
          end
        end
        `ADDR_LINE_CTRL:
        begin
          rd_val = {24'h000000, s.line_ctrl_q};
        end
        `ADDR_LINE_STATUS:
        begin
          rd_val = {24'h000000, lsr};
          // a read retires the error flags, except those set right now
          n.overrun_q = rx_set & s.ready_q;
          n.parity_q = rx_set & i_rx_event.parity_err;
          n.frame_q = rx_set & i_rx_event.frame_err;
          n.break_q = 1'b0;
        end
        `ADDR_SECOND_STATUS:
        begin
          rd_val = {31'h00000000, s.modem_q};
          n.modem_q = i_modem_event;
        end
        `ADDR_FRAC_DIV:
        begin
          rd_val = {16'h0000, s.frac_q};
        end
        default:
        begin
          rd_resp = `RESP_SLVERR; // unmapped read answers zero with an error
        end
      endcase
      n.rdata_q = rd_val;
      n.rresp_q = rd_resp;
      n.rvalid_q = 1'b1;
    end
    else if (s.rvalid_q && i_rready)
    begin
      n.rvalid_q = 1'b0;
    end

    // write decode once both halves are held
    if (do_wr)
    begin
      case (s.awaddr_q)
        `ADDR_TX_RX:
        begin
          if (latch_sel)
          begin
            n.div_q[7:0] = (s.div_q[7:0] & ~wmask[7:0]) | (s.wdata_q[7:0] & wmask[7:0]);
          end
          else if (s.wstrb_q[0])
          begin
            // a write is taken at once, even while the shifter still sends
            n.hold_data_q = s.wdata_q[7:0];
            n.hold_full_q = 1'b1;
            n.tx_pend_q = 1'b0;
          end
        end
        `ADDR_IRQ_EN:
        begin
          if (latch_sel)
          begin
            n.div_q[15:8] = (s.div_q[15:8] & ~wmask[7:0]) | (s.wdata_q[7:0] & wmask[7:0]);
          end
          else if (s.wstrb_q[0])
          begin
            // bits 7:4 are not stored; bit 3 is kept but software leaves it zero
            n.irq_en_q = s.wdata_q[7:0] & `IEN_WMASK;
            // enabling tx empty while the holding register is empty flags it at once
            if (s.wdata_q[`IEN_TX_BIT] && !s.irq_en_q[`IEN_TX_BIT] && !s.hold_full_q)
            begin
              n.tx_pend_q = 1'b1;
            end
          end
        end
        `ADDR_LINE_CTRL:
        begin
          n.line_ctrl_q = (s.line_ctrl_q & ~wmask[7:0]) | (s.wdata_q[7:0] & wmask[7:0]);
        end
        `ADDR_FRAC_DIV:
        begin
          // reserved bits 14:13 never store, so they read as zero
          n.frac_q = ((s.frac_q & ~wmask) | (s.wdata_q[15:0] & wmask)) & `FRAC_WMASK;
        end
        `ADDR_IRQ_IDENT, `ADDR_LINE_STATUS, `ADDR_SECOND_STATUS:
        begin
          wr_resp = `RESP_OKAY; // read-only registers ignore writes
        end
        default:
        begin
          wr_resp = `RESP_SLVERR;
        end
      endcase
      n.aw_held_q = 1'b0;
      n.w_held_q = 1'b0;
      n.bresp_q = wr_resp;
      n.bvalid_q = 1'b1;
    end
    else if (s.bvalid_q && i_bready)
    begin
      n.bvalid_q = 1'b0;
    end
    // readies: one write and one read in flight at a time
    n.awready_q = ~n.aw_held_q & ~n.bvalid_q;
    n.wready_q = ~n.w_held_q & ~n.bvalid_q;
    n.arready_q = ~n.rvalid_q;
    // hand the holding register to the shifter when it is free
    n.tx_load_q = 1'b0;
    if (s.hold_full_q && !s.tx_load_q && !i_tx_busy && !do_wr)
    begin
      n.tx_load_q = 1'b1;
      n.tx_data_q = s.hold_data_q;
      n.hold_full_q = 1'b0;
      n.tx_pend_q = 1'b1;
    end
    // pin synchroniser, a level counts once the second and third stages agree
    n.sync_q = {s.sync_q[1:0], i_serial_rx_line};
    if (s.sync_q[1] == s.sync_q[2])
    begin
      n.line_q = s.sync_q[2];
    end
    // count bit times the line stays low; saturates one past a whole frame
    if (s.line_q)
    begin
      n.low_bits_q = 4'h0;
    end
    else if (i_bit_tick && (s.low_bits_q <= `MAX_FRAME_BITS))
    begin
      n.low_bits_q = s.low_bits_q + 4'h1;
      if (s.low_bits_q == `MAX_FRAME_BITS)
      begin
        n.break_q = 1'b1;
      end
    end

    // fractional settings as the baud logic needs them
    n.frac_cfg_q.en = n.frac_q[`FRAC_EN_BIT];
    n.frac_cfg_q.m = (n.frac_q[`FRAC_M_HI:`FRAC_M_LO] == 2'h0) ? `FRAC_M_ZERO_MEANS
                     : {1'b0, n.frac_q[`FRAC_M_HI:`FRAC_M_LO]};
    n.frac_cfg_q.n = n.frac_q[`FRAC_N_HI:0];

    // sources gated by their enables, from the updated flags
    ls_on = n.irq_en_q[`IEN_LINE_BIT] & (n.frame_q | n.parity_q | n.overrun_q);
    rx_on = n.irq_en_q[`IEN_RX_BIT] & n.ready_q;
    tx_on = n.irq_en_q[`IEN_TX_BIT] & n.tx_pend_q & ~n.hold_full_q;
    ms_on = n.irq_en_q[`IEN_MODEM_BIT] & n.modem_q;
    // fixed priority, re-evaluated every cycle so a cleared source hands over at once
    if (ls_on)
    begin
      n.iid_q = `IID_LINE;
    end
    else if (rx_on)
    begin
      n.iid_q = `IID_RXFULL;
    end
    else if (tx_on)
    begin
      n.iid_q = `IID_TXEMPTY;
    end
    else if (ms_on)
    begin
      n.iid_q = `IID_MODEM;
    end
    else
    begin
      n.iid_q = `IID_NONE;
    end
    n.irq_q = ls_on | rx_on | tx_on | ms_on;
  end

  // state register; reset loads constants only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s <= '0;
      s.irq_en_q <= `IEN_RST;
      s.iid_q <= `IID_RST;
      s.frac_q <= `FRAC_RST;
      s.frac_cfg_q.m <= `FRAC_M_ZERO_MEANS;
      s.sync_q <= 3'h7;
      s.line_q <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  // every output is a flip-flop of the state
  assign o_awready = s.awready_q;
  assign o_wready = s.wready_q;
  assign o_bresp = s.bresp_q;
  assign o_bvalid = s.bvalid_q;
  assign o_arready = s.arready_q;
  assign o_rdata = s.rdata_q;
  assign o_rresp = s.rresp_q;
  assign o_rvalid = s.rvalid_q;
  assign o_tx_load = s.tx_load_q;
  assign o_tx_data = s.tx_data_q;
  assign o_line_ctrl = s.line_ctrl_q;
  assign o_divisor = s.div_q;
  assign o_frac_cfg = s.frac_cfg_q;
  assign o_irq = s.irq_q;

endmodule

// *** bench/uart_status_irq_fracdiv_checker.sv ***
// port assertions for the uart status, interrupt and divider block
`timescale 1ns/10ps
module uart_status_irq_fracdiv_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_arvalid,
  input wire logic i_rready,
  input wire logic i_bready,
  input wire logic i_tx_busy,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_tx_load,
  input wire uart_sir_pkg::frac_cfg_t o_frac_cfg
);
  // single domain, so one clock and one reset for all
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // read address handed over
  sequence s_ar_taken;
    i_arvalid && o_arready;
  endsequence
  // read answer waiting on the master
  sequence s_r_stall;
    o_rvalid && !i_rready;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> o_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_r_stall |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_write_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write answer dropped");
  a_ar_blocked: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answering");
  a_aw_blocked: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while answering");
  a_load_when_idle: assert property (o_tx_load |-> !$past(i_tx_busy))
    else $error("load while shifter busy");
  a_load_one_pulse: assert property (o_tx_load |=> !o_tx_load)
    else $error("load pulse too long");
  a_frac_m_range: assert property (o_frac_cfg.m != 3'h0 && o_frac_cfg.m <= 3'h4)
    else $error("m factor out of range");
endmodule

// *** bench/uart_far_side.sv ***
// far-side model: transmit and receive shifters, bit clock and serial pin
`timescale 1ns/10ps
module uart_far_side (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_tx_load,
  input wire logic i_send,
  input wire logic [7:0] i_data,
  input wire logic i_perr,
  input wire logic i_ferr,
  input wire logic i_line_low,
  output uart_sir_pkg::rx_event_t o_rx_event,
  output logic o_tx_busy,
  output logic o_bit_tick,
  output logic o_serial_rx_line
);
  logic [5:0] busy_q; // cycles left on the shifter
  logic [1:0] tick_q; // bit time is four clocks, short to keep runs brief
  // shifter busy from the cycle after a load; data garbled outside a char
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      busy_q <= 6'h00;
      tick_q <= 2'h0;
      o_bit_tick <= 1'b0;
      o_rx_event <= '0;
    end
    else
    begin
      tick_q <= tick_q + 2'h1;
      o_bit_tick <= (tick_q == 2'h3);
      o_rx_event <= '{i_send, i_send ? i_data : ~o_rx_event.data, i_perr, i_ferr};
      if (i_tx_load)
        busy_q <= 6'h28;
      else if (busy_q != 6'h00)
        busy_q <= busy_q - 6'h01;
    end
  end
  assign o_tx_busy = (busy_q != 6'h00);
  // released pin floats high through the pull-up
  assign o_serial_rx_line = ~i_line_low;
endmodule

// *** bench/test_uart_status_irq_fracdiv.sv ***
// self-checking bench for the uart status, interrupt and divider block
`timescale 1ns/10ps
`include "uart_sir_regs.svh"
module test_uart_status_irq_fracdiv;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic i_arvalid = 1'b0, i_rready = 1'b0, i_modem_event = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata, load_cnt = 32'h0;
  logic [3:0] i_wstrb = 4'hF; // whole word each time
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_load, o_irq, i_tx_busy;
  logic i_bit_tick, i_serial_rx_line;
  logic [1:0] o_bresp, o_rresp;
  logic [7:0] o_tx_data, o_line_ctrl, load_data;
  logic [15:0] o_divisor;
  uart_sir_pkg::frac_cfg_t o_frac_cfg;
  uart_sir_pkg::rx_event_t i_rx_event;
  logic send = 1'b0, perr = 1'b0, ferr = 1'b0, line_low = 1'b0;
  logic [7:0] sdata = 8'h00;
  int error_cnt = 0, check_count = 0;
  uart_status_irq_fracdiv u_uart_status_irq_fracdiv (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_rx_event(i_rx_event),
    .i_tx_busy(i_tx_busy), .i_modem_event(i_modem_event), .i_bit_tick(i_bit_tick),
    .i_serial_rx_line(i_serial_rx_line), .o_tx_load(o_tx_load), .o_tx_data(o_tx_data), .o_line_ctrl(o_line_ctrl),
    .o_divisor(o_divisor), .o_frac_cfg(o_frac_cfg), .o_irq(o_irq));
  uart_far_side u_uart_far_side (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tx_load(o_tx_load), .i_send(send),
    .i_data(sdata), .i_perr(perr), .i_ferr(ferr), .i_line_low(line_low), .o_rx_event(i_rx_event),
    .o_tx_busy(i_tx_busy), .o_bit_tick(i_bit_tick), .o_serial_rx_line(i_serial_rx_line));
  always #2 i_clk = ~i_clk;
  // count loads so a pulse between bus calls is not missed
  always @(posedge i_clk)
  begin
    if (o_tx_load === 1'b1)
    begin
      load_cnt <= load_cnt + 32'h1;
      load_data <= o_tx_data;
    end
  end
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // both write halves offered together, each released once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r = `RESP_OKAY);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    while (pa || pw)
    begin
      @(posedge i_clk);
      if (o_awready === 1'b1) pa = 1'b0;
      if (o_wready === 1'b1) pw = 1'b0;
      i_awvalid <= pa;
      i_wvalid <= pw;
    end
    while (o_bvalid !== 1'b1) @(posedge i_clk);
    i_bready <= 1'b1;
    @(posedge i_clk);
    i_bready <= 1'b0;
    chk("bresp", {32'h0, r}, {32'h0, o_bresp});
  endtask
  // ready raised late on purpose so the slave must hold its answer
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r = `RESP_OKAY);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    @(posedge i_clk);
    while (o_arready !== 1'b1) @(posedge i_clk);
    i_arvalid <= 1'b0;
    while (o_rvalid !== 1'b1) @(posedge i_clk);
    i_rready <= 1'b1;
    @(posedge i_clk);
    i_rready <= 1'b0;
    chk("read", {r, e}, {o_rresp, o_rdata});
  endtask
  // one received character from the far side
  task automatic snd(input logic [7:0] d, input logic p, input logic f);
    send <= 1'b1;
    sdata <= d;
    perr <= p;
    ferr <= f;
    @(posedge i_clk);
    send <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic wait_load(input logic [31:0] n, input logic [7:0] d);
    while (load_cnt < n) @(posedge i_clk);
    chk("tx_data", {26'h0, d}, {26'h0, load_data});
  endtask
  // hang guard, far beyond the several hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(`ADDR_LINE_STATUS, 32'h60);
    rd(`ADDR_IRQ_IDENT, 32'h01);
    rd(`ADDR_FRAC_DIV, 32'h0);
    wr(`ADDR_IRQ_EN, 32'hF7);
    rd(`ADDR_IRQ_EN, 32'h07);
    rd(`ADDR_IRQ_IDENT, 32'h02);
    rd(`ADDR_IRQ_IDENT, 32'h01);
    snd(8'hA5, 1'b0, 1'b0);
    chk("irq", 34'h1, {33'h0, o_irq});
    rd(`ADDR_LINE_STATUS, 32'h61);
    rd(`ADDR_IRQ_IDENT, 32'h04);
    rd(`ADDR_TX_RX, 32'hA5);
    rd(`ADDR_IRQ_IDENT, 32'h01);
    chk("irq", 34'h0, {33'h0, o_irq});
    // parity, framing, then overrun; data ready stays below the error code
    for (int i = 0; i < 3; i++)
    begin
      snd(8'(8'h30 + i), i == 0, i == 1);
      if (i == 2) snd(8'h3F, 1'b0, 1'b0);
      rd(`ADDR_IRQ_IDENT, 32'h06);
      rd(`ADDR_LINE_STATUS, i == 0 ? 32'h65 : i == 1 ? 32'h69 : 32'h63);
      rd(`ADDR_IRQ_IDENT, 32'h04);
      rd(`ADDR_TX_RX, i == 2 ? 32'h3F : 32'(8'h30 + i));
    end
    wr(`ADDR_TX_RX, 32'h3C);
    wait_load(32'h1, 8'h3C);
    rd(`ADDR_LINE_STATUS, 32'h20);
    rd(`ADDR_IRQ_IDENT, 32'h02);
    wr(`ADDR_TX_RX, 32'h5A);
    rd(`ADDR_LINE_STATUS, 32'h00);
    wait_load(32'h2, 8'h5A);
    repeat (50) @(posedge i_clk);
    rd(`ADDR_LINE_STATUS, 32'h60);
    // ten bit times low is short of a break, twenty is past it
    for (int k = 1; k <= 2; k++)
    begin
      line_low <= 1'b1;
      repeat (40 * k) @(posedge i_clk);
      line_low <= 1'b0;
      repeat (5) @(posedge i_clk);
      rd(`ADDR_LINE_STATUS, k == 2 ? 32'h70 : 32'h60);
    end
    rd(`ADDR_LINE_STATUS, 32'h60);
    wr(`ADDR_LINE_CTRL, 32'h80);
    chk("line_ctrl", 34'h80, {26'h0, o_line_ctrl});
    wr(`ADDR_TX_RX, 32'h34);
    wr(`ADDR_IRQ_EN, 32'h12);
    chk("divisor", 34'h1234, {18'h0, o_divisor});
    rd(`ADDR_IRQ_EN, 32'h12);
    wr(`ADDR_LINE_CTRL, 32'h00);
    rd(`ADDR_IRQ_EN, 32'h07);
    chk("loads", 34'h2, {2'h0, load_cnt});
    rd(32'hFFFF0730, 32'h0, `RESP_SLVERR);
    wr(32'hFFFF0730, 32'hFF, `RESP_SLVERR);
    i_modem_event <= 1'b1;
    @(posedge i_clk);
    i_modem_event <= 1'b0;
    rd(`ADDR_SECOND_STATUS, 32'h1);
    rd(`ADDR_SECOND_STATUS, 32'h0);
    // every m field, reserved bits written as ones
    for (int f = 0; f < 4; f++)
    begin
      wr(`ADDR_FRAC_DIV, 32'h0000E7FF | 32'(f << 11));
      rd(`ADDR_FRAC_DIV, 32'h000087FF | 32'(f << 11));
      chk("frac_cfg", {19'h0, 1'b1, f == 0 ? 3'h4 : 3'(f), 11'h7FF}, {19'h0, o_frac_cfg});
    end
    wr(`ADDR_FRAC_DIV, 32'h5);
    chk("frac_cfg", {19'h0, 1'b0, 3'h4, 11'h005}, {19'h0, o_frac_cfg});
    finish_test();
  end
endmodule
bind uart_status_irq_fracdiv uart_status_irq_fracdiv_checker u_uart_status_irq_fracdiv_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_arvalid(i_arvalid), .i_rready(i_rready), .i_bready(i_bready),
  .i_tx_busy(i_tx_busy), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_awready(o_awready),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .o_tx_load(o_tx_load), .o_frac_cfg(o_frac_cfg));
